// [adc_status_mode_pkg.sv]
/*
 * constants for the converter status and mode registers.
 * assumes a core with an 8-bit register port and bit addressing.
 */
// Summary of operation
// - primary done sets status bit 7
// - ready cleared by zero write or cal
// - ready set blocks result and coefficient updates
// - bit 6 is the auxiliary ready flag
// - calibration completion sets bit 5
// - bit 5 cleared only by start write
// - aux temperature-sensor calibration never completes
// - bit 4 flags bad main reference
// - bad reference forces results to ones
// - alternate reference pair never monitored
// - bit 3 flags saturated primary result
// - bit 3 flags failed primary calibration
// - error flags cleared by start write
// - bit 2 is the auxiliary error flag
// - status bits 1 and 0 unimplemented
// - status at d8, reset 00, bit addressable
// - mode at d1, reset 08, bit7 empty
// - bit 6 notch needs decimation word >=68
package adc_status_mode_pkg;
    localparam logic [7:0] STAT_ADDR = 8'hd8;
    localparam logic [7:0] MODE_ADDR = 8'hd1;
    localparam logic [7:0] STAT_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'h08;
    // status bit positions
    localparam int PRIM_RDY_BIT = 7;
    localparam int AUX_RDY_BIT = 6;
    localparam int CAL_BIT = 5;
    localparam int NOREF_BIT = 4;
    localparam int PRIM_ERR_BIT = 3;
    localparam int AUX_ERR_BIT = 2;
    // mode bit positions
    localparam int NOTCH_BIT = 6;
    localparam int PRIM_EN_BIT = 5;
    localparam int AUX_EN_BIT = 4;
    localparam int CHOP_OFF_BIT = 3;
    localparam int MODE_MSB = 2;
    // conversion mode codes: at or above these a write starts work
    localparam logic [2:0] MODE_CONV_MIN = 3'h2;
    localparam logic [2:0] MODE_CAL_MIN = 3'h4;
    // bit address page of the status register (d8..df)
    localparam logic [4:0] STAT_BIT_PAGE = 5'h1b;
    localparam logic [7:0] NOTCH_MIN_DECIM = 8'h44;
    localparam int RES_W = 24;
endpackage

// [adc_status_mode_properties.sv]
/*
 * concurrent checks on the converter status and mode register block.
 * assumes one clock domain, clk, with async active-low reset_n.
 */
`timescale 1ns/1ns
`default_nettype none
module adc_status_mode_props (
    input wire logic clk, // clock
    input wire logic reset_n, // reset, low
    input wire logic [7:0] sfr_addr, // address
    input wire logic sfr_wr, // write strobe
    input wire logic [7:0] sfr_wdata, // write data
    input wire logic [7:0] decimation_word, // filter word
    input wire logic prim_conv_done, // primary result
    input wire logic prim_cal_done, // primary cal
    input wire logic prim_clamped, // saturated
    input wire logic aux_conv_done, // aux result
    input wire logic aux_cal_done, // aux cal
    input wire logic aux_temp_sel, // temp input
    input wire logic [23:0] prim_data_q, // result
    input wire logic [23:0] prim_cal_q, // coefficient
    input wire logic primary_done_flag, // bit 7
    input wire logic aux_done_flag, // bit 6
    input wire logic missing_ref_flag, // bit 4
    input wire logic primary_clamp_error, // bit 3
    input wire logic aux_clamp_error, // bit 2
    input wire logic prim_en, // primary on
    input wire logic aux_en, // aux on
    input wire logic second_notch_select, // notch
    input wire logic mode_start_q, // start pulse
    input wire logic mode_cal_q // cal pulse
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // set wins over clear, so clearing checks skip cycles with an event
    wire no_event = !prim_conv_done && !prim_cal_done && !aux_conv_done && !aux_cal_done;
    sequence mode_start_write;
        sfr_wr && sfr_addr == 8'hd1 && sfr_wdata[2:0] >= 3'h2;
    endsequence
    a_prim_ready_set: assert property ((prim_conv_done || prim_cal_done) |=> primary_done_flag)
        else $error("primary ready not set");
    a_aux_ready_set: assert property (aux_conv_done |=> aux_done_flag)
        else $error("aux ready not set");
    a_ready_blocks_data: assert property (primary_done_flag |=> $stable(prim_data_q) && $stable(prim_cal_q))
        else $error("result changed while ready");
    a_clamp_sets_err: assert property (prim_conv_done && prim_clamped
        && !primary_done_flag |=> primary_clamp_error)
        else $error("clamp error not set");
    a_temp_cal_dead: assert property (aux_cal_done && aux_temp_sel && !aux_conv_done && !aux_done_flag
        |=> !aux_done_flag)
        else $error("temp sensor cal completed");
    a_ref_idle_gate: assert property ((!prim_en && !aux_en) [*2] |-> !missing_ref_flag)
        else $error("reference flag while idle");
    a_noref_ones: assert property (missing_ref_flag && prim_conv_done && !primary_done_flag
        |=> prim_data_q == 24'hffffff)
        else $error("result not forced to ones");
    a_start_err_clear: assert property (mode_start_write ##0 no_event
        |=> !primary_clamp_error && !aux_clamp_error)
        else $error("error flags survive start");
    a_cal_ready_clear: assert property (mode_start_write ##0 (sfr_wdata[2] && sfr_wdata[5] && no_event)
        |=> !primary_done_flag)
        else $error("ready survives cal start");
    a_start_pulse_kind: assert property (mode_start_write |=> mode_start_q && mode_cal_q == $past(sfr_wdata[2]))
        else $error("start pulse wrong");
    a_notch_gate: assert property (second_notch_select |-> $past(decimation_word) >= 8'h44)
        else $error("notch with small decimation");
endmodule
bind adc_status_mode_regs adc_status_mode_props adc_status_mode_props_i (.*);
`default_nettype wire

// [adc_status_mode_regs.sv]
/*
 * status and mode registers of the two sigma-delta converters:
 * the status byte with its ready, calibration, reference and
 * error flags, the mode byte, and the result and coefficient
 * holding registers that the ready flags guard.
 * assumes the core drives the register port on clk and the
 * converter datapath reports done/clamp/fail as one-cycle pulses
 * on clk, with data and qualifiers valid in the same cycle;
 * reference detect comes from analog comparators with no relation
 * to clk, so it is resynchronised here.
 */
`timescale 1ns/1ns
`default_nettype none
module adc_status_mode_regs (
    input wire logic clk, // 10 MHz core clock
    input wire logic reset_n, // async reset, low
    input wire logic [7:0] sfr_addr, // register address
    input wire logic sfr_wr, // byte write strobe
    input wire logic sfr_rd, // byte read strobe
    input wire logic [7:0] sfr_wdata, // write data
    output logic [7:0] sfr_rdata_q, // read data
    input wire logic [7:0] bit_addr, // bit address
    input wire logic bit_wr, // bit write strobe
    input wire logic bit_rd, // bit read strobe
    input wire logic bit_wdata, // bit write value
    output logic bit_rdata_q, // bit read value
    input wire logic [7:0] decimation_word, // filter word
    input wire logic prim_conv_done, // primary result pulse
    input wire logic prim_cal_done, // primary cal pulse
    input wire logic prim_clamped, // result saturated
    input wire logic prim_cal_fail, // cal error
    input wire logic [23:0] prim_result, // raw result
    input wire logic [23:0] prim_coef, // new coefficient
    input wire logic aux_conv_done, // aux result pulse
    input wire logic aux_cal_done, // aux cal pulse
    input wire logic aux_clamped, // aux saturated
    input wire logic aux_cal_fail, // aux cal error
    input wire logic aux_temp_sel, // temp sensor input
    input wire logic [23:0] aux_result, // raw aux result
    input wire logic [23:0] aux_coef, // new aux coefficient
    input wire logic ref_float, // main pair floating
    input wire logic ref_low, // main pair low
    output logic [23:0] prim_data_q, // primary result
    output logic [23:0] prim_cal_q, // primary coefficient
    output logic [23:0] aux_data_q, // aux result
    output logic [23:0] aux_cal_q, // aux coefficient
    output logic primary_done_flag, // status bit 7
    output logic aux_done_flag, // status bit 6
    output logic missing_ref_flag, // status bit 4
    output logic primary_clamp_error, // status bit 3
    output logic aux_clamp_error, // status bit 2
    output logic [2:0] conversion_mode_field, // mode bits
    output logic prim_en, // primary enable
    output logic aux_en, // aux enable
    output logic chop_off, // chop disable
    output logic second_notch_select, // notch active
    output logic mode_start_q, // start pulse
    output logic mode_cal_q // start is cal
);

    // flag update: set wins over clear, so an event that lands in the
    // same cycle as a software clear is never lost
    function automatic logic flag_next(
        input logic q,
        input logic set,
        input logic clr
    );
        flag_next = set | (q & ~clr);
    endfunction

    // work is started by a mode field at or above a threshold;
    // used for both the start and the calibration decode
    function automatic logic mode_at_least(
        input logic [2:0] md,
        input logic [2:0] lim
    );
        mode_at_least = (md >= lim);
    endfunction

    // mode byte and its next value
    logic [7:0] mode_q;
    logic [7:0] mode_d;
    // status flags
    logic prdy_q;
    logic ardy_q;
    logic cal_q;
    logic noref_q;
    logic perr_q;
    logic aerr_q;
    // registered mode side effects
    logic notch_q;
    logic start_q;
    logic calst_q;
    // read data holding registers
    logic [7:0] rdata_q;
    logic brd_q;
    // result and coefficient holding registers
    logic [23:0] pdat_q;
    logic [23:0] pcal_q;
    logic [23:0] adat_q;
    logic [23:0] acal_q;
    // reference detect synchroniser and accepted level
    logic [2:0] ref_sync_q;
    logic ref_bad_q;

    // register decode; reads need no strobe here, the read register
    // only loads when sfr_rd is high
    wire stat_wr = sfr_wr && (sfr_addr == adc_status_mode_pkg::STAT_ADDR);
    wire mode_wr = sfr_wr && (sfr_addr == adc_status_mode_pkg::MODE_ADDR);
    wire stat_rd = (sfr_addr == adc_status_mode_pkg::STAT_ADDR);
    wire mode_rd = (sfr_addr == adc_status_mode_pkg::MODE_ADDR);
    // the status byte is the only bit addressable register here
    wire bit_hit = (bit_addr[7:3] == adc_status_mode_pkg::STAT_BIT_PAGE);
    wire [2:0] bit_idx = bit_addr[2:0];

    // mode write decode; every write to the register is a mode-bit write
    // any mode write
    wire [2:0] wr_md = sfr_wdata[adc_status_mode_pkg::MODE_MSB:0];
    wire wr_start = mode_wr && mode_at_least(wr_md, adc_status_mode_pkg::MODE_CONV_MIN);
    wire wr_cal = mode_wr && mode_at_least(wr_md, adc_status_mode_pkg::MODE_CAL_MIN);
    // enable bits come from the written value, not the old one
    wire wr_pen = sfr_wdata[adc_status_mode_pkg::PRIM_EN_BIT];
    wire wr_aen = sfr_wdata[adc_status_mode_pkg::AUX_EN_BIT];

    // writing one to the top bit is harmless; it is never stored
    // bit 7 stays empty
    assign mode_d = mode_wr ? {1'b0, sfr_wdata[6:0]} : mode_q;

    // direct software clear of ready flags, by byte or by bit write;
    // a written one is ignored, software can never set a ready flag
    // zero write clears
    wire sw_clr_prdy = (stat_wr && !sfr_wdata[adc_status_mode_pkg::PRIM_RDY_BIT])
        || (bit_wr && bit_hit && !bit_wdata
            && (bit_idx == 3'(adc_status_mode_pkg::PRIM_RDY_BIT)));
    wire sw_clr_ardy = (stat_wr && !sfr_wdata[adc_status_mode_pkg::AUX_RDY_BIT])
        || (bit_wr && bit_hit && !bit_wdata
            && (bit_idx == 3'(adc_status_mode_pkg::AUX_RDY_BIT)));

    // a calibration start only clears the converters it enables
    // calibration start clears
    wire clr_prdy = sw_clr_prdy || (wr_cal && wr_pen);
    wire clr_ardy = sw_clr_ardy || (wr_cal && wr_aen);

    // the sensor path cannot settle a calibration, so its pulse is void
    // temp sensor cal
    wire acal_ok = aux_cal_done && !aux_temp_sel;

    // a blocked result write leaves data and the error flag untouched; a failed cal still sets it
    // blocked while ready
    wire p_res_we = prim_conv_done && !prdy_q;
    wire p_cal_we = prim_cal_done && !prdy_q && !prim_cal_fail;
    wire a_res_we = aux_conv_done && !ardy_q;
    wire a_cal_we = acal_ok && !ardy_q && !aux_cal_fail;

    // ready is set even when the data write itself was blocked
    // primary done
    wire set_prdy = prim_conv_done || prim_cal_done;
    wire set_ardy = aux_conv_done || acal_ok;
    wire set_cal = prim_cal_done || acal_ok;

    // reference forcing counts as saturation for the error flag
    // saturated result
    wire set_perr = (p_res_we && (prim_clamped || noref_q))
        || (prim_cal_done && prim_cal_fail);
    wire set_aerr = (a_res_we && (aux_clamped || noref_q))
        || (acal_ok && aux_cal_fail);

    // forcing sits before the guard, so a blocked write stays blocked
    // forced all ones
    wire [23:0] p_res = noref_q ? {adc_status_mode_pkg::RES_W{1'b1}} : prim_result;
    wire [23:0] a_res = noref_q ? {adc_status_mode_pkg::RES_W{1'b1}} : aux_result;

    wire ref_raw = ref_float | ref_low;
    // comparator levels change on their own time; accept once stages 2 and 3 agree
    wire ref_agree = (ref_sync_q[1] == ref_sync_q[2]);
    // the reference only counts while a converter is powered up
    wire conv_active = mode_q[adc_status_mode_pkg::PRIM_EN_BIT]
        || mode_q[adc_status_mode_pkg::AUX_EN_BIT];

    // the bit may still be written; it is masked while the word is small
    // notch needs word
    wire notch_ok = mode_q[adc_status_mode_pkg::NOTCH_BIT]
        && (decimation_word >= adc_status_mode_pkg::NOTCH_MIN_DECIM);

    // two spare bits keep the byte layout of the status register
    // low bits read zero
    wire [7:0] stat_view = {prdy_q, ardy_q, cal_q, noref_q, perr_q, aerr_q, 2'b00};

    // read mux; unmapped addresses read zero
    // a bit read outside the status page returns zero as well
    wire [7:0] rd_mux = stat_rd ? stat_view : (mode_rd ? mode_q : 8'h00);
    wire brd_mux = bit_hit ? stat_view[bit_idx] : 1'b0;

    // reference detect synchroniser, three stages; the first stage may
    // go metastable, so only stages 2 and 3 feed the decision, and a
    // level that flickers between them is held off until it settles
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ref_sync_q <= 3'h0;
            ref_bad_q <= 1'b0;
        end else begin
            ref_sync_q <= {ref_sync_q[1:0], ref_raw};
            if (ref_agree) begin
                ref_bad_q <= ref_sync_q[2];
            end
        end
    end

    // mode register and derived pulses; the start pulses last one
    // cycle and the converters latch the request themselves
    // mode reset 08
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_q <= adc_status_mode_pkg::MODE_RESET;
            notch_q <= 1'b0;
            start_q <= 1'b0;
            calst_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            notch_q <= notch_ok;
            start_q <= wr_start;
            calst_q <= wr_cal;
        end
    end

    // ready flags; hardware set always beats a same-cycle clear
    // status reset 00
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prdy_q <= adc_status_mode_pkg::STAT_RESET[adc_status_mode_pkg::PRIM_RDY_BIT];
            ardy_q <= adc_status_mode_pkg::STAT_RESET[adc_status_mode_pkg::AUX_RDY_BIT];
        end else begin
            prdy_q <= flag_next(prdy_q, set_prdy, clr_prdy);
            ardy_q <= flag_next(ardy_q, set_ardy, clr_ardy);
        end
    end

    // calibration and reference flags
    // status reset 00
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cal_q <= adc_status_mode_pkg::STAT_RESET[adc_status_mode_pkg::CAL_BIT];
            noref_q <= adc_status_mode_pkg::STAT_RESET[adc_status_mode_pkg::NOREF_BIT];
        end else begin
            cal_q <= flag_next(cal_q, set_cal, wr_start);
            noref_q <= ref_bad_q && conv_active;
        end
    end

    // error flags; a start write clears both converters at once
    // status reset 00
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            perr_q <= adc_status_mode_pkg::STAT_RESET[adc_status_mode_pkg::PRIM_ERR_BIT];
            aerr_q <= adc_status_mode_pkg::STAT_RESET[adc_status_mode_pkg::AUX_ERR_BIT];
        end else begin
            perr_q <= flag_next(perr_q, set_perr, wr_start);
            aerr_q <= flag_next(aerr_q, set_aerr, wr_start);
        end
    end

    // primary result and coefficient registers; a blocked write is
    // dropped, not queued, so software must clear ready in time
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pdat_q <= 24'h000000;
            pcal_q <= 24'h000000;
        end else begin
            if (p_res_we) begin
                pdat_q <= p_res;
            end
            if (p_cal_we) begin
                pcal_q <= prim_coef;
            end
        end
    end

    // auxiliary result and coefficient registers, same guard
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            adat_q <= 24'h000000;
            acal_q <= 24'h000000;
        end else begin
            if (a_res_we) begin
                adat_q <= a_res;
            end
            if (a_cal_we) begin
                acal_q <= aux_coef;
            end
        end
    end

    // read data registered one cycle after the strobe; it holds until
    // the next strobe, so the core may pick it up late
    // bit read path
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= 8'h00;
            brd_q <= 1'b0;
        end else begin
            if (sfr_rd) begin
                rdata_q <= rd_mux;
            end
            if (bit_rd) begin
                brd_q <= brd_mux;
            end
        end
    end

    // outputs, each a flip-flop
    assign sfr_rdata_q = rdata_q;
    assign bit_rdata_q = brd_q;

    // held results and coefficients
    assign prim_data_q = pdat_q;
    assign prim_cal_q = pcal_q;
    assign aux_data_q = adat_q;
    assign aux_cal_q = acal_q;

    // status flags; the calibration flag is only seen through a read
    assign primary_done_flag = prdy_q;
    assign aux_done_flag = ardy_q;
    assign missing_ref_flag = noref_q;
    assign primary_clamp_error = perr_q;
    assign aux_clamp_error = aerr_q;

    // mode byte fields and start pulses
    assign conversion_mode_field = mode_q[adc_status_mode_pkg::MODE_MSB:0];
    assign prim_en = mode_q[adc_status_mode_pkg::PRIM_EN_BIT];
    assign aux_en = mode_q[adc_status_mode_pkg::AUX_EN_BIT];
    assign chop_off = mode_q[adc_status_mode_pkg::CHOP_OFF_BIT];
    assign second_notch_select = notch_q;
    assign mode_start_q = start_q;
    assign mode_cal_q = calst_q;

endmodule
`default_nettype wire

// [adc_status_mode_regs_bench.sv]
/*
 * self-checking bench for the converter status and mode registers.
 * assumes the design registers every answer one edge after the strobe.
 */
`timescale 1ns/1ns
`default_nettype none
module adc_status_mode_regs_bench;
    logic clk, reset_n, sfr_wr, sfr_rd, bit_wr, bit_rd, bit_wdata, bit_rdata_q;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata_q, bit_addr, decimation_word;
    logic prim_conv_done, prim_cal_done, prim_clamped, prim_cal_fail, aux_conv_done;
    logic aux_cal_done, aux_clamped, aux_cal_fail, aux_temp_sel, ref_float, ref_low;
    logic [23:0] prim_result, prim_coef, aux_result, aux_coef;
    logic [23:0] prim_data_q, prim_cal_q, aux_data_q, aux_cal_q;
    logic primary_done_flag, aux_done_flag, missing_ref_flag, primary_clamp_error;
    logic aux_clamp_error, prim_en, aux_en, chop_off, second_notch_select;
    logic mode_start_q, mode_cal_q;
    logic [2:0] conversion_mode_field;
    int error_cnt, tests_run;
    adc_status_mode_regs adc_status_mode_regs_i (.*);
    // free-running core clock, 100 ns period
    always #50 clk = ~clk;
    task chk(input logic [23:0] seen, input logic [23:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // byte write; strobe drops right after the taking edge
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
        #1;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk);
        sfr_rd <= 1'b0;
        #1;
        chk(sfr_rdata_q, exp);
    endtask
    // single-bit access; is_rd selects read instead of write
    task bacc(input logic is_rd, input logic [7:0] a, input logic v);
        @(posedge clk);
        bit_addr <= a;
        bit_wdata <= v;
        bit_wr <= !is_rd;
        bit_rd <= is_rd;
        @(posedge clk);
        {bit_wr, bit_rd} <= 2'b00;
        #1;
        if (is_rd)
            chk(bit_rdata_q, v);
    endtask
    // one converter event pulse: conv, cal, clamp, fail, temp select
    task ev(input logic aux, cv, cl, cm, fl, tp, input logic [23:0] r);
        @(posedge clk);
        {prim_conv_done, prim_cal_done, prim_clamped, prim_cal_fail} <= aux ? 4'h0 : {cv, cl, cm, fl};
        {aux_conv_done, aux_cal_done, aux_clamped, aux_cal_fail} <= aux ? {cv, cl, cm, fl} : 4'h0;
        aux_temp_sel <= tp;
        {prim_result, prim_coef, aux_result, aux_coef} <= {4{r}};
        @(posedge clk);
        {prim_conv_done, prim_cal_done, aux_conv_done, aux_cal_done} <= 4'h0;
        #1;
    endtask
    // bounded wait; the reference path has a few flops of latency
    task await_ref(input logic v);
        for (int i = 0; i < 12 && missing_ref_flag !== v; i++) begin
            @(posedge clk);
            #1;
        end
        chk(missing_ref_flag, v);
        if (missing_ref_flag !== v)
            close_out();
    endtask
    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        {sfr_wr, sfr_rd, bit_wr, bit_rd, bit_wdata, sfr_addr, sfr_wdata, bit_addr} = '0;
        {prim_conv_done, prim_cal_done, prim_clamped, prim_cal_fail, aux_conv_done} = '0;
        {aux_cal_done, aux_clamped, aux_cal_fail, aux_temp_sel, ref_float, ref_low} = '0;
        {prim_result, prim_coef, aux_result, aux_coef} = '0;
        decimation_word = 8'h52;
        error_cnt = 0;
        tests_run = 0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        rd(8'hd8, 8'h00);
        rd(8'hd1, 8'h08);
        chk({prim_en, aux_en, chop_off, conversion_mode_field}, 6'h08);
        rd(8'h55, 8'h00);
        ev(0, 1, 0, 0, 0, 0, 24'ha5a5a5);
        chk(prim_data_q, 24'ha5a5a5);
        ev(0, 1, 0, 0, 0, 0, 24'h111111);
        chk(prim_data_q, 24'ha5a5a5);
        bacc(1'b1, 8'hdf, 1'b1);
        bacc(1'b0, 8'hdf, 1'b0);
        chk(primary_done_flag, 1'b0);
        wr(8'hd8, 8'hff);
        rd(8'hd8, 8'h00);
        ev(0, 1, 0, 1, 0, 0, 24'h000000);
        ev(1, 1, 0, 1, 0, 0, 24'h000abc);
        chk(aux_data_q, 24'h000abc);
        rd(8'hd8, 8'hcc);
        wr(8'hd1, 8'h34);
        chk({mode_start_q, mode_cal_q}, 2'b11);
        chk({prim_en, aux_en, chop_off, conversion_mode_field}, 6'h34);
        rd(8'hd8, 8'h00);
        ev(0, 0, 1, 0, 0, 0, 24'h0c0c0c);
        rd(8'hd8, 8'ha0);
        chk(prim_cal_q, 24'h0c0c0c);
        wr(8'hd1, 8'h34);
        rd(8'hd8, 8'h00);
        ev(0, 0, 1, 0, 1, 0, 24'h777777);
        chk(prim_cal_q, 24'h0c0c0c);
        chk(primary_clamp_error, 1'b1);
        wr(8'hd1, 8'h34);
        ev(1, 0, 1, 0, 0, 1, 24'h333333);
        rd(8'hd8, 8'h00);
        chk(aux_cal_q, 24'h000000);
        wr(8'hd1, 8'h04);
        @(posedge clk);
        ref_low <= 1'b1;
        repeat (10) @(posedge clk);
        #1;
        chk(missing_ref_flag, 1'b0);
        ev(0, 1, 0, 1, 0, 0, 24'h000000);
        bacc(1'b0, 8'hdf, 1'b0);
        wr(8'hd1, 8'h22);
        chk({primary_clamp_error, mode_start_q, mode_cal_q}, 3'b010);
        await_ref(1'b1);
        ev(0, 1, 0, 0, 0, 0, 24'h123456);
        chk(prim_data_q, 24'hffffff);
        @(posedge clk);
        {ref_low, ref_float} <= 2'b01;
        repeat (8) @(posedge clk);
        #1;
        chk(missing_ref_flag, 1'b1);
        @(posedge clk);
        ref_float <= 1'b0;
        await_ref(1'b0);
        @(posedge clk);
        decimation_word <= 8'h43;
        wr(8'hd1, 8'hc0);
        @(posedge clk);
        #1;
        chk(second_notch_select, 1'b0);
        rd(8'hd1, 8'h40);
        @(posedge clk);
        decimation_word <= 8'h44;
        repeat (2) @(posedge clk);
        #1;
        chk(second_notch_select, 1'b1);
        close_out();
    end
endmodule
`default_nettype wire
